// ==== shared/tsc_pkg.sv ====
// Purpose: constants and types for the two-speed start-up and fail-safe clock block
// Assumes: 8-bit registers, one per aligned 32-bit word
// Notes: oscillator mode codes and reset values are plain defaults
package tsc_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_OSC_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_CFG_OSC   = 8'h04;
	localparam logic [7:0] ADDR_CFG_PU    = 8'h08;
	localparam logic [7:0] ADDR_IRQ_FLAG  = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_EN    = 8'h10;
	localparam logic [7:0] ADDR_STATUS    = 8'h14;
	// field positions
	localparam int OSC_IDLE_BIT  = 7;
	localparam int OSC_IFS_LSB   = 4;
	localparam int OSC_STARTUP_TIMEOUT_STATUS_BIT  = 3;
	localparam int OSC_SCS_LSB   = 0;
	localparam int CFG_TSE_BIT   = 7;
	localparam int CFG_FME_BIT   = 6;
	localparam int CFG_FOSC_LSB  = 0;
	localparam int PU_EN_BIT     = 0;
	localparam int FLAG_BIT      = 7;
	localparam int EN_BIT        = 7;
	localparam int ST_SRC_LSB    = 0;
	localparam int ST_FAIL_BIT   = 2;
	localparam int ST_HOLD_BIT   = 3;
	localparam int ST_MODE_LSB   = 4;
	// reset values
	localparam logic [2:0] IFS_RST   = 3'h3;
	localparam logic [3:0] FOSC_RST  = 4'h2;
	localparam logic       TSE_RST   = 1'h0;
	localparam logic       FME_RST   = 1'h0;
	localparam logic       PU_EN_RST = 1'h0;
	// primary oscillator modes
	localparam logic [3:0] FOSC_LP   = 4'h0;
	localparam logic [3:0] FOSC_XT   = 4'h1;
	localparam logic [3:0] FOSC_HS   = 4'h2;
	localparam logic [3:0] FOSC_EC   = 4'h4;
	localparam logic [3:0] FOSC_RC   = 4'h6;
	localparam logic [3:0] FOSC_RESISTOR_CAPACITOR_IO_MODE = 4'h7;
	// source select codes
	localparam logic [1:0] SCS_PRI = 2'h0;
	localparam logic [1:0] SCS_SEC = 2'h1;
	// timing counts
	localparam int OST_COUNT  = 1024;
	localparam int SAMPLE_DIV = 64;
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {SRC_PRI, SRC_SEC, SRC_INT} tsc_src_type;
	typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_SLEEP} tsc_pm_type;
	typedef enum logic [2:0] {SW_IDLE, SW_OLD, SW_HOLD, SW_NEW, SW_REL} tsc_sw_type;

	function automatic logic is_xtal(input logic [3:0] f);
		return (f == FOSC_LP) || (f == FOSC_XT) || (f == FOSC_HS);
	endfunction

	function automatic logic is_ext(input logic [3:0] f);
		return is_xtal(f) || (f == FOSC_EC) || (f == FOSC_RC) || (f == FOSC_RESISTOR_CAPACITOR_IO_MODE);
	endfunction
endpackage

// ==== hw/tsc_sync.sv ====
// Purpose: three-stage pin synchroniser with edge pulses
// Assumes: pin is asynchronous to aclk
// Notes: a change counts once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module tsc_sync (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// pin side
	input  wire logic pin,
	// synchronised side
	output var  logic level,
	output var  logic rise,
	output var  logic fall
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
		logic rise;
		logic fall;
	} tsc_sync_type;

	tsc_sync_type r_r;
	tsc_sync_type r_nxt;

	always_comb begin
		r_nxt = r_r;
		r_nxt.s1 = pin;
		r_nxt.s2 = r_r.s1;
		r_nxt.s3 = r_r.s2;
		r_nxt.rise = 1'b0;
		r_nxt.fall = 1'b0;
		if (r_r.s2 == r_r.s3 && r_r.s3 != r_r.lvl) begin
			r_nxt.lvl = r_r.s3;
			r_nxt.rise = r_r.s3;
			r_nxt.fall = !r_r.s3;
		end
		if (!aresetn) begin
			r_nxt = '0;
		end
	end

	always_ff @(posedge aclk) begin
		r_r <= r_nxt;
	end

	assign level = r_r.lvl;
	assign rise = r_r.rise;
	assign fall = r_r.fall;
endmodule
`default_nettype wire

// ==== hw/tsc_clk_switch.sv ====
// Purpose: glitch-free switch sequencer between two clock sources
// Assumes: edge pulses of old and new source in the aclk domain
// Notes: a dead old source must be given as steady edge pulses
`timescale 1ns/1ns
`default_nettype none
module tsc_clk_switch (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// request, new source already ready
	input  wire logic start,
	// source edges
	input  wire logic old_rise,
	input  wire logic old_fall,
	input  wire logic new_rise,
	input  wire logic new_fall,
	// status
	output var  logic hold,
	output var  logic busy,
	output var  logic done
);
	typedef struct packed {
		tsc_pkg::tsc_sw_type st;
		logic                cnt;
		logic                hold;
		logic                done;
	} tsc_swst_type;

	tsc_swst_type r_r;
	tsc_swst_type r_nxt;

	always_comb begin
		r_nxt = r_r;
		r_nxt.done = 1'b0;
		unique case (r_r.st)
			tsc_pkg::SW_IDLE: begin
				if (start) begin
					r_nxt.st = tsc_pkg::SW_OLD;
					r_nxt.cnt = 1'b0;
				end
			end
			tsc_pkg::SW_OLD: begin
				if (old_rise) begin
					r_nxt.cnt = 1'b1;
					if (r_r.cnt) begin
						r_nxt.st = tsc_pkg::SW_HOLD;
					end
				end
			end
			tsc_pkg::SW_HOLD: begin
				if (old_fall) begin
					r_nxt.hold = 1'b1;
					r_nxt.cnt = 1'b0;
					r_nxt.st = tsc_pkg::SW_NEW;
				end
			end
			tsc_pkg::SW_NEW: begin
				if (new_rise) begin
					r_nxt.cnt = 1'b1;
					if (r_r.cnt) begin
						r_nxt.st = tsc_pkg::SW_REL;
					end
				end
			end
			tsc_pkg::SW_REL: begin
				if (new_fall) begin
					r_nxt.hold = 1'b0;
					r_nxt.done = 1'b1;
					r_nxt.st = tsc_pkg::SW_IDLE;
				end
			end
			default: begin
				r_nxt.st = tsc_pkg::SW_IDLE;
			end
		endcase
		if (!aresetn) begin
			r_nxt = '0;
		end
	end

	always_ff @(posedge aclk) begin
		r_r <= r_nxt;
	end

	assign hold = r_r.hold;
	assign busy = (r_r.st != tsc_pkg::SW_IDLE);
	assign done = r_r.done;
endmodule
`default_nettype wire

// ==== hw/tsc_clock_supervisor.sv ====
// Purpose: two-speed start-up, fail-safe clock monitor and source selection
// Assumes: oscillators arrive as pins sampled by aclk; AXI4-Lite register access
// Notes: the system clock itself is muxed outside; this block steers it
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module tsc_clock_supervisor #(
	parameter int OST_CYCLES = tsc_pkg::OST_COUNT,
	parameter int SAMPLE_DIV = tsc_pkg::SAMPLE_DIV
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// oscillator pins
	input  wire logic        ext_osc_in,
	input  wire logic        lf_osc_in,
	input  wire logic        hf_osc_in,
	input  wire logic        sec_osc_in,
	// core events, same clock
	input  wire logic        sleep_req,
	input  wire logic        wake_req,
	input  wire logic        power_up_timer_expired,
	// clock steering
	output var  logic [1:0]  sys_src,
	output var  logic        sys_clk_hold,
	output var  logic        cpu_clk_en,
	output var  logic        periph_clk_en,
	output var  logic [2:0]  int_freq_sel,
	output var  logic        osc_fail_irq
);
	localparam int OW = $clog2(OST_CYCLES);
	localparam int DW = $clog2(SAMPLE_DIV);

	typedef struct packed {
		logic                awrdy;
		logic                bvld;
		logic [1:0]          bresp;
		logic                arrdy;
		logic                rvld;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
		logic                idle_en;
		logic [2:0]          ifs;
		logic [1:0]          scs;
		logic                tse;
		logic                fme;
		logic [3:0]          fosc;
		logic                power_up_timer_en;
		logic                flag;
		logic                irq_en;
		logic                irq;
		tsc_pkg::tsc_pm_type mode;
		logic                power_up_timer_wait;
		logic                ost_run;
		logic                ost_done;
		logic [OW-1:0]       ost_cnt;
		logic                startup_timeout_status;
		logic [DW-1:0]       div;
		logic                latch;
		logic                fail_det;
		logic                fail_safe;
		tsc_pkg::tsc_src_type cur;
		tsc_pkg::tsc_src_type tgt;
		logic                sw_go;
		logic                cpu_en;
		logic                per_en;
	} tsc_state_type;

	tsc_state_type r_r;
	tsc_state_type r_nxt;

	// synchronised pins
	logic ext_rise, ext_fall, lf_rise, lf_fall;
	logic hf_rise, hf_fall, sec_rise, sec_fall;
	logic int_rise, int_fall;
	// switch sequencer
	logic sw_hold, sw_busy, sw_done, old_dead;
	logic old_rise, old_fall, new_rise, new_fall;
	// decode and control terms
	logic       wr, rd, wr_ok, rd_ok;
	logic [2:0] wr_idx, rd_idx;
	logic [7:0] rd_val, wbyte;
	logic       samp_rise, samp_fall, monitor, ts_active;
	logic       ost_go, tgt_ready;
	tsc_pkg::tsc_src_type tgt;

	function automatic logic [3:0] reg_dec(input logic [7:0] a);
		unique case (a)
			tsc_pkg::ADDR_OSC_CTRL: reg_dec = 4'h8;
			tsc_pkg::ADDR_CFG_OSC:  reg_dec = 4'h9;
			tsc_pkg::ADDR_CFG_PU:   reg_dec = 4'ha;
			tsc_pkg::ADDR_IRQ_FLAG: reg_dec = 4'hb;
			tsc_pkg::ADDR_IRQ_EN:   reg_dec = 4'hc;
			tsc_pkg::ADDR_STATUS:   reg_dec = 4'hd;
			default:                reg_dec = 4'h0;
		endcase
	endfunction

	function automatic logic pick(input tsc_pkg::tsc_src_type s, input logic p,
			input logic c, input logic i);
		unique case (s)
			tsc_pkg::SRC_PRI: pick = p;
			tsc_pkg::SRC_SEC: pick = c;
			default:          pick = i;
		endcase
	endfunction

	tsc_sync u_ext (.aclk(aclk), .aresetn(aresetn), .pin(ext_osc_in),
		.level(), .rise(ext_rise), .fall(ext_fall));
	tsc_sync u_lf (.aclk(aclk), .aresetn(aresetn), .pin(lf_osc_in),
		.level(), .rise(lf_rise), .fall(lf_fall));
	tsc_sync u_hf (.aclk(aclk), .aresetn(aresetn), .pin(hf_osc_in),
		.level(), .rise(hf_rise), .fall(hf_fall));
	tsc_sync u_sec (.aclk(aclk), .aresetn(aresetn), .pin(sec_osc_in),
		.level(), .rise(sec_rise), .fall(sec_fall));

	assign int_rise = (r_r.ifs == 3'h0) ? lf_rise : hf_rise;
	assign int_fall = (r_r.ifs == 3'h0) ? lf_fall : hf_fall;

	// a failed or unstarted crystal gives no edges, so do not wait on it
	assign old_dead = (r_r.cur == tsc_pkg::SRC_PRI) && (!r_r.ost_done || r_r.fail_safe);
	assign old_rise = old_dead || pick(r_r.cur, ext_rise, sec_rise, int_rise);
	assign old_fall = old_dead || pick(r_r.cur, ext_fall, sec_fall, int_fall);
	assign new_rise = pick(r_r.tgt, ext_rise, sec_rise, int_rise);
	assign new_fall = pick(r_r.tgt, ext_fall, sec_fall, int_fall);

	tsc_clk_switch u_sw (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.start    (r_r.sw_go),
		.old_rise (old_rise),
		.old_fall (old_fall),
		.new_rise (new_rise),
		.new_fall (new_fall),
		.hold     (sw_hold),
		.busy     (sw_busy),
		.done     (sw_done)
	);

	always_comb begin
		r_nxt = r_r;
		wr = r_r.awrdy && s_axi_awvalid && s_axi_wvalid;
		rd = r_r.arrdy && s_axi_arvalid;
		{wr_ok, wr_idx} = reg_dec(s_axi_awaddr);
		{rd_ok, rd_idx} = reg_dec(s_axi_araddr);
		wbyte = s_axi_wdata[7:0];
		ost_go = 1'b0;

		// bus slave: address and data taken together, one at a time
		r_nxt.awrdy = !r_r.awrdy && !r_r.bvld && s_axi_awvalid && s_axi_wvalid;
		if (wr) begin
			r_nxt.bvld = 1'b1;
			r_nxt.bresp = wr_ok ? tsc_pkg::RESP_OKAY : tsc_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			r_nxt.bvld = 1'b0;
		end
		r_nxt.arrdy = !r_r.arrdy && !r_r.rvld && s_axi_arvalid;

		rd_val = 8'h00;
		unique case (rd_idx)
			3'h0: rd_val = {r_r.idle_en, r_r.ifs, r_r.startup_timeout_status, 1'b0, r_r.scs};
			3'h1: rd_val = {r_r.tse, r_r.fme, 2'h0, r_r.fosc};
			3'h2: rd_val = {7'h00, r_r.power_up_timer_en};
			3'h3: rd_val = {r_r.flag, 7'h00};
			3'h4: rd_val = {r_r.irq_en, 7'h00};
			3'h5: rd_val = {2'h0, r_r.mode, sw_hold, r_r.fail_safe, r_r.cur};
			default: rd_val = 8'h00;
		endcase
		if (rd) begin
			r_nxt.rvld = 1'b1;
			r_nxt.rdata = {24'h000000, rd_ok ? rd_val : 8'h00};
			r_nxt.rresp = rd_ok ? tsc_pkg::RESP_OKAY : tsc_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			r_nxt.rvld = 1'b0;
		end

		if (wr && wr_ok && s_axi_wstrb[0]) begin
			unique case (wr_idx)
				3'h0: begin
					r_nxt.idle_en = wbyte[tsc_pkg::OSC_IDLE_BIT];
					r_nxt.ifs = wbyte[tsc_pkg::OSC_IFS_LSB +: 3];
					r_nxt.scs = wbyte[tsc_pkg::OSC_SCS_LSB +: 2];
					if (r_r.fail_safe && (wbyte[tsc_pkg::OSC_SCS_LSB + 1] != r_r.scs[1])) begin
						ost_go = 1'b1;
					end
					// primary was shut down while away, start it again
					if (!r_r.fail_safe && r_r.scs != tsc_pkg::SCS_PRI
							&& wbyte[tsc_pkg::OSC_SCS_LSB +: 2] == tsc_pkg::SCS_PRI) begin
						ost_go = 1'b1;
					end
				end
				3'h1: begin
					r_nxt.tse = wbyte[tsc_pkg::CFG_TSE_BIT];
					r_nxt.fme = wbyte[tsc_pkg::CFG_FME_BIT];
					r_nxt.fosc = wbyte[tsc_pkg::CFG_FOSC_LSB +: 4];
				end
				3'h2: r_nxt.power_up_timer_en = wbyte[tsc_pkg::PU_EN_BIT];
				3'h3: r_nxt.flag = wbyte[tsc_pkg::FLAG_BIT];
				3'h4: r_nxt.irq_en = wbyte[tsc_pkg::EN_BIT];
				default: r_nxt.flag = r_r.flag;
			endcase
		end

		if (r_r.power_up_timer_wait && (!r_r.power_up_timer_en || power_up_timer_expired)) begin
			r_nxt.power_up_timer_wait = 1'b0;
			ost_go = 1'b1;
		end

		unique case (r_r.mode)
			tsc_pkg::PM_RUN: begin
				if (sleep_req) begin
					r_nxt.mode = r_r.idle_en ? tsc_pkg::PM_IDLE : tsc_pkg::PM_SLEEP;
				end
			end
			tsc_pkg::PM_IDLE: begin
				if (wake_req) begin
					r_nxt.mode = tsc_pkg::PM_RUN;
				end
			end
			tsc_pkg::PM_SLEEP: begin
				if (wake_req) begin
					r_nxt.mode = tsc_pkg::PM_RUN;
					ost_go = 1'b1;
				end
			end
			default: r_nxt.mode = tsc_pkg::PM_RUN;
		endcase

		if (r_r.ost_run && ext_fall) begin
			r_nxt.ost_cnt = r_r.ost_cnt + 1'b1;
			if (r_r.ost_cnt == OW'(OST_CYCLES - 1)) begin
				r_nxt.ost_run = 1'b0;
				r_nxt.ost_done = 1'b1;
				r_nxt.fail_safe = 1'b0;
			end
		end
		if (ost_go) begin
			r_nxt.ost_cnt = '0;
			r_nxt.ost_run = tsc_pkg::is_xtal(r_r.fosc);
			r_nxt.ost_done = !tsc_pkg::is_xtal(r_r.fosc);
		end
		// the crystal stops in sleep; timeout aborted
		if (r_nxt.mode == tsc_pkg::PM_SLEEP) begin
			r_nxt.ost_run = 1'b0;
			r_nxt.ost_done = 1'b0;
		end

		r_nxt.startup_timeout_status = r_r.ost_done && !r_r.fail_safe && r_r.scs == tsc_pkg::SCS_PRI
			&& tsc_pkg::is_ext(r_r.fosc);

		samp_rise = 1'b0;
		samp_fall = 1'b0;
		if (lf_rise) begin
			r_nxt.div = r_r.div + 1'b1;
			samp_rise = (r_r.div == DW'(SAMPLE_DIV / 2 - 1));
			samp_fall = (r_r.div == DW'(SAMPLE_DIV - 1));
		end
		monitor = r_r.fme && tsc_pkg::is_ext(r_r.fosc) && r_r.ost_done && !r_r.fail_safe
			&& r_r.mode != tsc_pkg::PM_SLEEP;
		if (ext_fall) begin
			r_nxt.latch = 1'b1;
		end else if (samp_rise) begin
			r_nxt.latch = 1'b0;
		end
		r_nxt.fail_det = monitor && samp_fall && !r_r.latch;
		if (r_r.fail_det && !r_r.fail_safe) begin
			r_nxt.fail_safe = 1'b1;
			r_nxt.flag = 1'b1;
		end
		r_nxt.irq = r_r.flag && r_r.irq_en;

		ts_active = r_r.tse && r_r.scs == tsc_pkg::SCS_PRI && tsc_pkg::is_xtal(r_r.fosc)
			&& !r_r.ost_done;
		if (r_r.fail_safe || ts_active || r_r.scs[1]) begin
			tgt = tsc_pkg::SRC_INT;
		end else if (r_r.scs == tsc_pkg::SCS_SEC) begin
			tgt = tsc_pkg::SRC_SEC;
		end else begin
			tgt = tsc_pkg::SRC_PRI;
		end
		tgt_ready = (tgt != tsc_pkg::SRC_PRI) || r_r.ost_done;
		r_nxt.sw_go = 1'b0;
		if (!sw_busy && !r_r.sw_go && !sw_done && tgt != r_r.cur && tgt_ready) begin
			r_nxt.sw_go = 1'b1;
			r_nxt.tgt = tgt;
		end
		if (sw_done) begin
			r_nxt.cur = r_r.tgt;
		end

		r_nxt.cpu_en = r_r.mode == tsc_pkg::PM_RUN && !r_r.power_up_timer_wait
			&& !(tgt == tsc_pkg::SRC_PRI && !r_r.ost_done && r_r.cur != tsc_pkg::SRC_SEC);
		r_nxt.per_en = r_r.mode != tsc_pkg::PM_SLEEP && !r_r.power_up_timer_wait;

		if (!aresetn) begin
			r_nxt = '0;
			r_nxt.ifs = tsc_pkg::IFS_RST;
			r_nxt.fosc = tsc_pkg::FOSC_RST;
			r_nxt.tse = tsc_pkg::TSE_RST;
			r_nxt.fme = tsc_pkg::FME_RST;
			r_nxt.power_up_timer_en = tsc_pkg::PU_EN_RST;
			r_nxt.power_up_timer_wait = 1'b1;
			r_nxt.cur = tsc_pkg::SRC_INT;
			r_nxt.tgt = tsc_pkg::SRC_INT;
		end
	end

	always_ff @(posedge aclk) begin
		r_r <= r_nxt;
	end

	assign s_axi_awready = r_r.awrdy;
	assign s_axi_wready = r_r.awrdy;
	assign s_axi_bvalid = r_r.bvld;
	assign s_axi_bresp = r_r.bresp;
	assign s_axi_arready = r_r.arrdy;
	assign s_axi_rvalid = r_r.rvld;
	assign s_axi_rdata = r_r.rdata;
	assign s_axi_rresp = r_r.rresp;
	assign sys_src = r_r.cur;
	assign sys_clk_hold = sw_hold;
	assign cpu_clk_en = r_r.cpu_en;
	assign periph_clk_en = r_r.per_en;
	assign int_freq_sel = r_r.ifs;
	assign osc_fail_irq = r_r.irq;
endmodule
`default_nettype wire

// ==== bench/tsc_osc_model.sv ====
// Purpose: behavioural oscillator pin for the clock supervisor bench
// Assumes: half period is a multiple of 4 ns, so edges avoid the aclk rise
// Notes: a stopped crystal parks high, so no low edge reaches the monitor
`timescale 1ns/1ns
`default_nettype none
module tsc_osc_model #(
	parameter int HALF_NS = 16
) (
	// control
	input  wire logic run,
	// pin
	output var  logic osc
);
	initial begin
		osc = 1'b0;
		forever begin
			#(HALF_NS);
			osc = run ? ~osc : 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== bench/tsc_clock_supervisor_sva.sv ====
// Purpose: port checks for the clock supervisor
// Assumes: one aclk domain, synchronous active-low reset
// Notes: control bits are shadowed from accepted bus writes
`timescale 1ns/1ns
`default_nettype none
module tsc_clock_supervisor_sva #(
	parameter int OST_CYCLES = 16,
	parameter int SAMPLE_DIV = 8
) (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// register bus
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	// steering
	input wire logic        sleep_req,
	input wire logic [1:0]  sys_src,
	input wire logic        sys_clk_hold,
	input wire logic        cpu_clk_en,
	input wire logic        periph_clk_en,
	input wire logic [2:0]  int_freq_sel,
	input wire logic        osc_fail_irq
);
	logic       wr_take;
	logic       idle_r;
	logic       en_r;
	logic [2:0] ifs_r;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	assign wr_take = s_axi_awready && s_axi_awvalid && s_axi_wvalid && s_axi_wstrb[0];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			idle_r <= 1'b0;
			en_r <= 1'b0;
			ifs_r <= tsc_pkg::IFS_RST;
		end else if (wr_take && s_axi_awaddr == tsc_pkg::ADDR_OSC_CTRL) begin
			idle_r <= s_axi_wdata[tsc_pkg::OSC_IDLE_BIT];
			ifs_r <= s_axi_wdata[tsc_pkg::OSC_IFS_LSB +: 3];
		end else if (wr_take && s_axi_awaddr == tsc_pkg::ADDR_IRQ_EN) begin
			en_r <= s_axi_wdata[tsc_pkg::EN_BIT];
		end
	end
	AST_WR_ANSWER: assert property (s_axi_awready && s_axi_awvalid |=> s_axi_bvalid)
		else $error("write not answered");
	AST_RD_ANSWER: assert property (s_axi_arready && s_axi_arvalid |=>
		s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000) else $error("bad read answer");
	AST_SLEEP_STOP: assert property (sleep_req && !idle_r |->
		##[1:4] !cpu_clk_en && !periph_clk_en) else $error("sleep left a clock on");
	AST_IDLE_CPU: assert property (sleep_req && idle_r |->
		##[1:4] !cpu_clk_en && periph_clk_en) else $error("idle clocks wrong");
	AST_IRQ_GATE: assert property (osc_fail_irq |-> $past(en_r))
		else $error("irq without enable");
	AST_SRC_AFTER_HOLD: assert property ($changed(sys_src) |->
		$past(sys_clk_hold, 2) && !$past(sys_clk_hold)) else $error("source change unheld");
	AST_HOLD_SPAN: assert property ($rose(sys_clk_hold) |-> ##[1:200] !sys_clk_hold)
		else $error("hold never released");
	AST_FREQ_FOLLOW: assert property (wr_take && s_axi_awaddr == tsc_pkg::ADDR_OSC_CTRL |=>
		##[0:1] int_freq_sel == ifs_r) else $error("freq select not followed");
	AST_FAIL_TO_INT: assert property ($rose(osc_fail_irq) |-> ##[0:200] sys_src == 2'h2)
		else $error("no fallback to internal");
endmodule
bind tsc_clock_supervisor tsc_clock_supervisor_sva #(
	.OST_CYCLES(OST_CYCLES),
	.SAMPLE_DIV(SAMPLE_DIV)
) i_sva (
	.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wstrb, .s_axi_wvalid, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .sleep_req, .sys_src, .sys_clk_hold, .cpu_clk_en,
	.periph_clk_en, .int_freq_sel, .osc_fail_irq
);
`default_nettype wire

// ==== bench/tsc_clock_supervisor_bench.sv ====
// Purpose: directed bench for the clock supervisor through its register bus
// Assumes: short start-up and sample counts given as parameters
// Notes: oscillators are models gated by a run input (the crystal is stopped once), in fixed phase to aclk from time zero
`timescale 1ns/1ns
`default_nettype none
module tsc_clock_supervisor_bench;
	logic        aclk, aresetn, ext_run, lf_osc_in, hf_osc_in, sec_osc_in, ext_osc_in;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, sys_src;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        sleep_req, wake_req, power_up_timer_expired, sys_clk_hold, cpu_clk_en, periph_clk_en;
	logic        osc_fail_irq;
	logic        int_run;
	logic [2:0]  int_freq_sel;
	int          miscompares, compares;
	tsc_clock_supervisor #(.OST_CYCLES(16), .SAMPLE_DIV(8)) i_dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_osc_in, .lf_osc_in, .hf_osc_in,
		.sec_osc_in, .sleep_req, .wake_req, .power_up_timer_expired, .sys_src, .sys_clk_hold,
		.cpu_clk_en, .periph_clk_en, .int_freq_sel, .osc_fail_irq
	);
	tsc_osc_model i_ext (.run(ext_run), .osc(ext_osc_in));
	tsc_osc_model #(.HALF_NS(24)) i_lf (.run(int_run), .osc(lf_osc_in));
	tsc_osc_model #(.HALF_NS(12)) i_hf (.run(int_run), .osc(hf_osc_in));
	tsc_osc_model #(.HALF_NS(20)) i_sec (.run(int_run), .osc(sec_osc_in));
	initial aclk = 1'b0;
	always #2 aclk = ~aclk;
	task automatic summarize();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_awready !== 1'b1 && n++ < 99);
		chk(32'(s_axi_wready), 32'h1, "wready");
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1 && n++ < 99);
		s_axi_bready <= 1'b0;
		chk(32'(n > 99), 32'h0, "write wait");
		chk(32'(s_axi_bresp), 32'(er), "bresp");
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1 && n++ < 99);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1 && n++ < 99);
		s_axi_rready <= 1'b0;
		chk(32'(n > 99), 32'h0, "read wait");
		chk(s_axi_rdata, {24'h000000, ed}, "rdata");
		chk(32'(s_axi_rresp), 32'(er), "rresp");
	endtask
	// one-cycle sleep or wake pulse, then let the mode settle
	task automatic ev(input logic wake);
		@(posedge aclk);
		sleep_req <= !wake;
		wake_req <= wake;
		@(posedge aclk);
		sleep_req <= 1'b0;
		wake_req <= 1'b0;
		repeat (6) @(posedge aclk);
	endtask
	task automatic wait_src(input logic [1:0] s, input int lim);
		int n;
		n = 0;
		while (sys_src !== s && n < lim) begin
			@(posedge aclk);
			n++;
		end
		chk(32'(sys_src), 32'(s), "sys_src");
	endtask
	initial begin
		miscompares = 0;
		compares = 0;
		aresetn = 1'b0;
		ext_run = 1'b1;
		int_run = 1'b1;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'h1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{sleep_req, wake_req, power_up_timer_expired} = 3'h0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(32'(sys_src), 32'h2, "reset source");
		rd(tsc_pkg::ADDR_OSC_CTRL, 8'h30, tsc_pkg::RESP_OKAY);
		wait_src(2'h0, 2000);
		rd(tsc_pkg::ADDR_OSC_CTRL, 8'h38, tsc_pkg::RESP_OKAY);
		$display("test reset and start-up done");
		wr(tsc_pkg::ADDR_CFG_OSC, 8'hc2, tsc_pkg::RESP_OKAY);
		ev(1'b0);
		chk(32'({cpu_clk_en, periph_clk_en}), 32'h0, "sleep clocks");
		ev(1'b1);
		wait_src(2'h2, 200);
		chk(32'(cpu_clk_en), 32'h1, "cpu runs on internal");
		rd(tsc_pkg::ADDR_OSC_CTRL, 8'h30, tsc_pkg::RESP_OKAY);
		wait_src(2'h0, 2000);
		rd(tsc_pkg::ADDR_OSC_CTRL, 8'h38, tsc_pkg::RESP_OKAY);
		$display("test two-speed wake done");
		ext_run <= 1'b0;
		wait_src(2'h2, 1000);
		chk(32'(osc_fail_irq), 32'h0, "irq masked");
		rd(tsc_pkg::ADDR_IRQ_FLAG, 8'h80, tsc_pkg::RESP_OKAY);
		rd(tsc_pkg::ADDR_STATUS, 8'h06, tsc_pkg::RESP_OKAY);
		wr(tsc_pkg::ADDR_IRQ_EN, 8'h80, tsc_pkg::RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk(32'(osc_fail_irq), 32'h1, "irq raised");
		ext_run <= 1'b1;
		repeat (300) @(posedge aclk);
		chk(32'(sys_src), 32'h2, "no auto return");
		wr(tsc_pkg::ADDR_IRQ_FLAG, 8'h00, tsc_pkg::RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk(32'(osc_fail_irq), 32'h0, "irq cleared");
		rd(tsc_pkg::ADDR_STATUS, 8'h06, tsc_pkg::RESP_OKAY);
		wr(tsc_pkg::ADDR_OSC_CTRL, 8'h32, tsc_pkg::RESP_OKAY);
		wr(tsc_pkg::ADDR_OSC_CTRL, 8'h30, tsc_pkg::RESP_OKAY);
		wait_src(2'h0, 2000);
		rd(tsc_pkg::ADDR_STATUS, 8'h00, tsc_pkg::RESP_OKAY);
		$display("test fail-safe done");
		wr(tsc_pkg::ADDR_OSC_CTRL, 8'hd1, tsc_pkg::RESP_OKAY);
		wait_src(2'h1, 300);
		chk(32'(int_freq_sel), 32'h5, "freq select");
		ev(1'b0);
		chk(32'({cpu_clk_en, periph_clk_en}), 32'h1, "idle clocks");
		rd(tsc_pkg::ADDR_STATUS, 8'h11, tsc_pkg::RESP_OKAY);
		ev(1'b1);
		chk(32'(cpu_clk_en), 32'h1, "cpu after wake");
		wr(tsc_pkg::ADDR_OSC_CTRL, 8'h52, tsc_pkg::RESP_OKAY);
		wait_src(2'h2, 300);
		wr(8'h18, 8'hff, tsc_pkg::RESP_SLVERR);
		rd(8'h18, 8'h00, tsc_pkg::RESP_SLVERR);
		// strobe low: answered, nothing stored
		s_axi_wstrb <= 4'h0;
		wr(tsc_pkg::ADDR_OSC_CTRL, 8'h00, tsc_pkg::RESP_OKAY);
		s_axi_wstrb <= 4'h1;
		rd(tsc_pkg::ADDR_OSC_CTRL, 8'h52, tsc_pkg::RESP_OKAY);
		$display("test modes and bus done");
		// mid-run reset, two-speed now off
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		chk(32'(cpu_clk_en), 32'h0, "held for crystal");
		rd(tsc_pkg::ADDR_OSC_CTRL, 8'h30, tsc_pkg::RESP_OKAY);
		wait_src(2'h0, 2000);
		chk(32'(cpu_clk_en), 32'h1, "cpu on crystal");
		$display("test mid-run reset done");
		summarize();
	end
	// hang guard, well past the longest expected run
	initial begin
		repeat (40000) @(posedge aclk);
		miscompares++;
		$display("mismatch at %0t: watchdog", $time);
		summarize();
	end
endmodule
`default_nettype wire
